// ==== rtl/hbi_pkg.sv ====
// Functional notes
// - wait output floats whenever neither chip select is active.
// - chip select active with no strobe: wait driven high.
// - each strobe under select: wait low while busy, then high.
// - interrupt goes low when state matches programmed interrupt conditions.
// - any internal register access releases a pending interrupt.
// - interrupt is open drain plus a push-pull copy of equal value.
// - bus width select high gives 16-bit data bus, low 8-bit.
// - external reset clears state and registers to 0, some load initials.
// - dma request asserted when more drawing command data is needed.
// - map select high: registers reached through a 16-byte indirect window.
// - map select low: registers except color table direct in 128 bytes.
// - map select honoured in both compatibility and enhanced operation.
// - enhancement select high: only legacy registers, enhanced stay default.
// - enhancement select low: enhanced registers and double memory rate.
// - 8-bit mode: upper write strobe acts as address bit 0.
// - register space ignores A22-A4 indirect and A22-A8 direct.
// - ready low when access completes, high idle-selected, floats unselected.
// - data bus driven only while read strobe and a chip select active.
package hbi_pkg;

	localparam int          NUM_REGS    = 64;
	localparam int          IDX_W       = 6;
	localparam logic [5:0]  COMPAT_REGS = 6'h20;
	localparam logic [5:0]  IRQ_EN_IDX  = 6'h00;
	localparam logic [5:0]  INIT_IDX    = 6'h01;
	localparam logic [15:0] INIT_VAL    = 16'h0001;
	localparam logic [2:0]  WIN_DATA    = 3'h0;
	localparam logic [2:0]  WIN_INDEX   = 3'h1;

	typedef enum logic [1:0] {ST_IDLE, ST_BUSY, ST_MEMWAIT, ST_DONE} hbi_fsm_e;

	// raw pin levels, active-low strobes kept as on the wire
	typedef struct packed {
		logic        regSelN;
		logic        memSelN;
		logic        rdN;
		logic        wrLoN;
		logic        wrHiN;
		logic        grantN;
		logic        width;
		logic        mapSel;
		logic        enhN;
		logic [21:0] addr;
		logic [15:0] data;
	} hbi_pins_s;

	// synchroniser contents in reset: selects, strobes and grant idle high, mode pins
	// at their pulled-up level, so no false access or grant edge follows reset
	localparam hbi_pins_s PINS_IDLE = '{regSelN: 1'b1, memSelN: 1'b1, rdN: 1'b1, wrLoN: 1'b1,
		wrHiN: 1'b1, grantN: 1'b1, width: 1'b1, mapSel: 1'b1, enhN: 1'b1, addr: 22'h00_0000,
		data: 16'h0000};

	typedef struct packed {
		logic        valid;
		logic        write;
		logic [22:0] addr;
		logic [15:0] wdata;
		logic [1:0]  be;
	} hbi_memreq_s;

	typedef struct packed {
		hbi_pins_s                    sync1;
		hbi_pins_s                    sync2;
		hbi_fsm_e                     fsm;
		logic                         isMem;
		logic [NUM_REGS-1:0][15:0]    regs;
		logic [IDX_W-1:0]             index;
		logic                         irqPend;
		logic [15:0]                  dataOut;
		hbi_memreq_s                  memReq;
		logic                         grantPrev;
		logic                         dmaReq;
		logic                         cmdValid;
		logic [15:0]                  cmdWord;
	} hbi_state_s;

endpackage : hbi_pkg

// ==== rtl/hbi_host_port.sv ====
module hbi_host_port
	import hbi_pkg::*;
(
	input  wire  logic        clk,
	input  wire  logic        rstn,
	input  wire  logic        registerSpaceSelectN,
	input  wire  logic        memoryPortSelectN,
	input  wire  logic        rdN,
	input  wire  logic        lowerByteWriteStrobeN,
	input  wire  logic        upperByteWriteStrobeN,
	input  wire  logic [22:1] addrIn,
	input  wire  logic [15:0] dataIn,
	output       logic [15:0] dataOut,
	output       logic [1:0]  dataOeN,
	output       logic        waitOut,
	output       logic        waitOeN,
	output       logic        readyOutN,
	output       logic        readyOeN,
	output       logic        irqOut,
	output       logic        irqOeN,
	output       logic        pushPullIrqOutN,
	input  wire  logic        busWidthSelect,
	input  wire  logic        registerMapSelect,
	input  wire  logic        extendedFeatureSelectN,
	output       logic        dmaRequestOut,
	input  wire  logic        dmaGrantInN,
	input  wire  logic        cmdNeedData,
	output       logic        cmdWordValid,
	output       logic [15:0] cmdWord,
	input  wire  logic [7:0]  eventIn,
	output       hbi_memreq_s memReq,
	input  wire  logic        memAck,
	input  wire  logic [15:0] memRdata,
	output       logic        memDoubleRate
);

	////////////////////////////////////////////////////////////////////////////////
	hbi_state_s       q;
	hbi_state_s       n;
	hbi_pins_s        pinsIn;
	hbi_pins_s        p;
	logic             csAct;
	logic             is8;
	logic             a0;
	logic             wrLo;
	logic             wrHi;
	logic             rdAct;
	logic             strobe;
	logic             isWrite;
	logic [2:0]       winOff;
	logic             regHit;
	logic [IDX_W-1:0] regIdx;
	logic             regLocked;
	logic [15:0]      wdata;
	logic [1:0]       be;
	logic [15:0]      rdWord;
	logic             irqSet;
	logic             regAccess;
	logic             busyNow;

	assign pinsIn = '{regSelN: registerSpaceSelectN, memSelN: memoryPortSelectN,
		rdN: rdN, wrLoN: lowerByteWriteStrobeN, wrHiN: upperByteWriteStrobeN,
		grantN: dmaGrantInN, width: busWidthSelect, mapSel: registerMapSelect,
		enhN: extendedFeatureSelectN, addr: addrIn, data: dataIn};

	// all host pins are asynchronous, so decode only the second stage
	assign p = q.sync2;

	////////////////////////////////////////////////////////////////////////////////
	always_comb
	begin
		n       = q;
		n.sync1 = pinsIn;
		n.sync2 = q.sync1;
		csAct   = !p.regSelN || !p.memSelN;
		is8     = !p.width;
		a0      = is8 && p.wrHiN;
		wrLo    = !p.wrLoN;
		wrHi    = !is8 && !p.wrHiN;
		rdAct   = !p.rdN;
		strobe  = rdAct || wrLo || wrHi;
		isWrite = wrLo || wrHi;
		winOff  = p.addr[2:0];
		// map select decides decode regardless of the enhancement pin
		if (p.mapSel)
		begin
			regHit = (winOff == WIN_DATA);
			regIdx = q.index;
		end
		else
		begin
			regHit = !p.addr[6];
			regIdx = p.addr[5:0];
		end
		regLocked = p.enhN && (regIdx >= COMPAT_REGS);
		wdata     = is8 ? {p.data[7:0], p.data[7:0]} : p.data;
		be        = is8 ? {a0 && wrLo, !a0 && wrLo} : {wrHi, wrLo};
		rdWord    = 16'h0000;
		if (regHit && !regLocked)
		begin
			rdWord = q.regs[regIdx];
		end
		else if (p.mapSel && winOff == WIN_INDEX)
		begin
			rdWord = {10'h000, q.index};
		end
		n.memReq.valid = 1'b0;
		n.cmdValid     = 1'b0;
		regAccess      = 1'b0;
		unique case (q.fsm)
			ST_IDLE:
			begin
				if (csAct && strobe)
				begin
					n.fsm   = ST_BUSY;
					n.isMem = p.regSelN;
				end
			end
			ST_BUSY:
			begin
				if (q.isMem)
				begin
					n.memReq = '{valid: 1'b1, write: isWrite,
						addr: {p.addr, a0}, wdata: wdata, be: be};
					n.fsm    = ST_MEMWAIT;
				end
				else
				begin
					regAccess = 1'b1;
					if (isWrite)
					begin
						if (regHit && !regLocked)
						begin
							if (be[0])
							begin
								n.regs[regIdx][7:0] = wdata[7:0];
							end
							if (be[1])
							begin
								n.regs[regIdx][15:8] = wdata[15:8];
							end
						end
						else if (p.mapSel && winOff == WIN_INDEX && be[0])
						begin
							n.index = wdata[5:0];
						end
					end
					else
					begin
						n.dataOut = is8 ? {8'h00, a0 ? rdWord[15:8] : rdWord[7:0]} : rdWord;
					end
					n.fsm = ST_DONE;
				end
			end
			ST_MEMWAIT:
			begin
				if (memAck)
				begin
					n.dataOut = is8 ? {8'h00, a0 ? memRdata[15:8] : memRdata[7:0]}
						: memRdata;
					n.fsm     = ST_DONE;
				end
			end
			ST_DONE:
			begin
				// the host keeps its strobe until the done indication
				if (!csAct || !strobe)
				begin
					n.fsm = ST_IDLE;
				end
			end
		endcase
		// a new match in the clearing cycle wins over the clear
		irqSet = |(eventIn & q.regs[IRQ_EN_IDX][7:0]);
		if (irqSet)
		begin
			n.irqPend = 1'b1;
		end
		else if (regAccess)
		begin
			n.irqPend = 1'b0;
		end
		n.dmaReq    = cmdNeedData;
		n.grantPrev = p.grantN;
		if (q.grantPrev && !p.grantN)
		begin
			n.cmdValid = 1'b1;
			n.cmdWord  = p.data;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			q                <= '0;
			q.regs[INIT_IDX] <= INIT_VAL;
			q.grantPrev      <= 1'b1;
			// an all-zero synchroniser would look like a selected strobe and a grant edge
			q.sync1          <= PINS_IDLE;
			q.sync2          <= PINS_IDLE;
		end
		else
		begin
			q <= n;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// busy also covers the cycle the strobe is first seen, before the state moves
	assign busyNow   = (q.fsm == ST_BUSY) || (q.fsm == ST_MEMWAIT)
		|| (q.fsm == ST_IDLE && strobe);
	assign waitOeN   = !csAct;
	assign waitOut   = !busyNow;
	assign readyOeN  = !csAct;
	assign readyOutN = !(q.fsm == ST_DONE && strobe);
	assign dataOut   = q.dataOut;
	assign dataOeN   = {!(rdAct && csAct && !is8), !(rdAct && csAct)};
	assign irqOut          = 1'b0;
	assign irqOeN          = !q.irqPend;
	assign pushPullIrqOutN = !q.irqPend;
	assign dmaRequestOut   = q.dmaReq;
	assign cmdWordValid    = q.cmdValid;
	assign cmdWord         = q.cmdWord;
	assign memReq          = q.memReq;
	assign memDoubleRate   = !p.enhN;

	////////////////////////////////////////////////////////////////////////////////
	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	sequence regStart;
		q.fsm == ST_IDLE && strobe && !p.regSelN;
	endsequence

	sequence waitPulse;
		!waitOut ##1 !waitOut ##1 waitOut;
	endsequence

	sequence memIssue;
		q.fsm == ST_BUSY && q.isMem;
	endsequence

	chk_wait_float_off: assert property (!csAct |-> waitOeN && readyOeN)
		else $error("wait or ready driven while unselected");
	chk_wait_idle_high: assert property (csAct && !strobe |-> waitOut && readyOutN)
		else $error("wait or ready not high while idle-selected");
	chk_wait_reg_pulse: assert property (regStart |-> waitPulse)
		else $error("register access wait pulse wrong");
	chk_irq_set_event: assert property (irqSet |=> !irqOeN && !pushPullIrqOutN)
		else $error("interrupt not raised on matching event");
	chk_irq_access_clear: assert property (regAccess && !irqSet |=> irqOeN)
		else $error("register access did not release interrupt");
	chk_irq_two_outputs: assert property (irqOeN == pushPullIrqOutN && irqOut == 1'b0)
		else $error("interrupt outputs disagree");
	chk_bus_upper_lane: assert property (is8 |-> dataOeN[1])
		else $error("upper byte driven in 8-bit mode");
	chk_data_drive_gate: assert property (!dataOeN[0] |-> csAct && rdAct)
		else $error("data driven without read and select");
	chk_compat_reg_lock: assert property (regAccess && isWrite && regLocked |=> $stable(q.regs))
		else $error("enhanced register written in compatibility mode");
	chk_dma_req_follow: assert property (dmaRequestOut == $past(cmdNeedData))
		else $error("dma request does not follow need");
	chk_dma_grant_word: assert property (q.grantPrev && !p.grantN |=> cmdWordValid)
		else $error("grant edge did not yield a command word");
	// handshake completion, lanes, index load and locked reads
	chk_ready_done_low: assert property (q.fsm == ST_DONE && csAct && strobe
		|-> !readyOutN && !readyOeN && waitOut)
		else $error("ready not low with wait high when access done");
	chk_ready_not_early: assert property (q.fsm != ST_DONE |-> readyOutN)
		else $error("ready low before access done");
	chk_upper_lane_width: assert property (!dataOeN[1] |-> !dataOeN[0] && !is8)
		else $error("upper lane driven alone or in 8-bit mode");
	chk_byte_upper_zero: assert property (regAccess && !isWrite && is8
		|=> dataOut[15:8] == 8'h00)
		else $error("8-bit read left upper byte set");
	chk_index_write: assert property (regAccess && isWrite && p.mapSel
		&& winOff == WIN_INDEX && be[0] |=> q.index == $past(wdata[5:0]))
		else $error("index register not loaded");
	chk_lock_read_zero: assert property (regAccess && !isWrite && regHit && regLocked
		|=> dataOut == 16'h0000)
		else $error("locked register read not zero");
	// memory port
	chk_mem_req_issue: assert property (memIssue
		|=> memReq.valid && q.fsm == ST_MEMWAIT)
		else $error("memory request not issued");
	chk_mem_wait_low: assert property (q.fsm == ST_MEMWAIT && csAct |-> !waitOut)
		else $error("wait high while memory access pending");
	chk_mem_read_data: assert property (q.fsm == ST_MEMWAIT && memAck && !is8
		|=> dataOut == $past(memRdata))
		else $error("memory read data not latched");
	// interrupt, reset and dma
	chk_irq_hold_pend: assert property (!irqOeN && !regAccess |=> !irqOeN)
		else $error("interrupt dropped without register access");
	chk_reset_init_val: assert property ($rose(rstn) |-> q.regs[INIT_IDX] == INIT_VAL
		&& !q.irqPend && q.fsm == ST_IDLE)
		else $error("state after reset not at initial values");
	chk_grant_word_data: assert property (q.grantPrev && !p.grantN
		|=> cmdWord == $past(p.data))
		else $error("command word not taken from bus");
	chk_grant_single_pulse: assert property (cmdWordValid |=> !cmdWordValid)
		else $error("command word valid longer than one cycle");

endmodule : hbi_host_port

// ==== tb/hbi_mem_partner.sv ====
module hbi_mem_partner
	import hbi_pkg::*;
(
	input  wire logic         clk,
	input  wire logic         rstn,
	input  wire hbi_memreq_s  memReq,
	output      logic         memAck,
	output      logic [15:0]  memRdata
);
	timeunit 1ns;
	timeprecision 1ns;
	int cnt;
	// answers after one to three cycles; data toggles when not acking
	always_ff @(posedge clk or negedge rstn)
	begin
		if (!rstn)
		begin
			cnt <= 0;
			memAck <= 1'b0;
			memRdata <= 16'h0000;
		end
		else
		begin
			memAck <= (cnt == 1);
			memRdata <= (cnt == 1) ? 16'hc3a5 : ~memRdata;
			if (memReq.valid)
				cnt <= 1 + $urandom % 3;
			else if (cnt > 0)
				cnt <= cnt - 1;
		end
	end
endmodule : hbi_mem_partner

// ==== tb/hbi_host_port_tb.sv ====
module hbi_host_port_tb;
	timeunit 1ns;
	timeprecision 1ns;
	import hbi_pkg::*;
	logic clk, rstn, csR, csM, rdN, wrLoN, wrHiN, bw, ms, enhN, grN, need, mAck;
	logic [22:1] addr;
	logic [15:0] din, dout, mRd, cmdW, q, v;
	logic [1:0] doe;
	logic wt, wtOe, rdyN, rdyOe, irq, irqOe, ppIrq, dma_request_out, cmdV, dbl;
	logic [7:0] ev;
	hbi_memreq_s mReq, lastReq;
	int mismatches, n_compared, i;
	int mdl[64];
	hbi_host_port u_dut (.clk(clk), .rstn(rstn), .registerSpaceSelectN(csR),
		.memoryPortSelectN(csM), .rdN(rdN), .lowerByteWriteStrobeN(wrLoN),
		.upperByteWriteStrobeN(wrHiN), .addrIn(addr), .dataIn(din), .dataOut(dout),
		.dataOeN(doe), .waitOut(wt), .waitOeN(wtOe), .readyOutN(rdyN), .readyOeN(rdyOe),
		.irqOut(irq), .irqOeN(irqOe), .pushPullIrqOutN(ppIrq), .busWidthSelect(bw),
		.registerMapSelect(ms), .extendedFeatureSelectN(enhN), .dmaRequestOut(dma_request_out),
		.dmaGrantInN(grN), .cmdNeedData(need), .cmdWordValid(cmdV), .cmdWord(cmdW),
		.eventIn(ev), .memReq(mReq), .memAck(mAck), .memRdata(mRd), .memDoubleRate(dbl));
	hbi_mem_partner u_mem (.clk(clk), .rstn(rstn), .memReq(mReq), .memAck(mAck),
		.memRdata(mRd));
	initial
	begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	always @(posedge clk)
		if (mReq.valid === 1'b1)
			lastReq <= mReq;
	task chk(input string nm, input logic [31:0] seen, input logic [31:0] exp);
		n_compared++;
		if (seen !== exp)
		begin
			mismatches++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : chk
	task tally_and_finish;
		$display("mismatches %0d compared %0d", mismatches, n_compared);
		if (mismatches == 0 && n_compared > 0)
			$display("TEST PASSED");
		else
			$display("TEST FAILED");
		$finish;
	endtask : tally_and_finish
	// mode pins only move while reset is held, never during operation
	task rst(input logic w, input logic m, input logic e);
		@(negedge clk);
		{bw, ms, enhN, rstn} = {w, m, e, 1'b0};
		repeat (16) @(negedge clk);
		rstn = 1'b1;
		repeat (3) @(negedge clk);
		foreach (mdl[k]) mdl[k] = 0;
		mdl[1] = 1;
	endtask : rst
	// one host cycle; strobe held until wait high and ready low
	task acc(input bit mem, input bit wr, input logic [22:1] a, input logic hi,
		input logic [15:0] d);
		bit low;
		int n;
		low = 0;
		@(negedge clk);
		{addr, din, rdN, wrLoN} = {a, d, wr, !wr};
		wrHiN = bw ? !wr : hi;
		if (mem) csM = 1'b0;
		else csR = 1'b0;
		for (n = 0; n < 60 && !(rdyN === 1'b0 && wt === 1'b1); n++)
		begin
			@(posedge clk);
			#1;
			if (wt === 1'b0) low = 1;
		end
		if (n == 60)
		begin
			chk("timeout", 1, 0);
			tally_and_finish;
		end
		chk("waitLow", low, 1);
		if (!wr) chk("laneOe", doe, {!bw, 1'b0});
		q = bw ? dout : {8'h00, dout[7:0]};
		@(negedge clk);
		{csR, csM, rdN, wrLoN, wrHiN} = 5'h1f;
		repeat (3) @(negedge clk);
		chk("idleOe", {wtOe, rdyOe, doe}, 4'hf);
	endtask : acc
	function logic [22:1] adr(input int idx);
		if (ms) return 22'(($urandom & 22'h3f_fff8) | idx);
		return 22'(($urandom & 22'h3f_ff80) | idx);
	endfunction : adr
	task regWr(input int idx, input logic [15:0] val);
		if (ms) acc(0, 1, adr(1), 0, idx);
		if (ms) acc(0, 1, adr(0), 0, val);
		else if (bw) acc(0, 1, adr(idx), 0, val);
		else
		begin
			acc(0, 1, adr(idx), 0, val[7:0]);
			acc(0, 1, adr(idx), 1, val[15:8]);
		end
		if (!(enhN && idx >= 32)) mdl[idx] = val;
	endtask : regWr
	task regRd(input int idx);
		if (ms) acc(0, 1, adr(1), 0, idx);
		if (ms) acc(0, 0, adr(0), 0, 0);
		else if (bw) acc(0, 0, adr(idx), 0, 0);
		else
		begin
			acc(0, 0, adr(idx), 1, 0);
			v = q;
			acc(0, 0, adr(idx), 0, 0);
			q = {v[7:0], q[7:0]};
		end
		chk("regData", q, mdl[idx]);
	endtask : regRd
	initial
	begin
		{rstn, csR, csM, rdN, wrLoN, wrHiN, grN, need, bw, ms, enhN} = 11'h3f2;
		{addr, din, ev, lastReq} = '0;
		void'($urandom(13));
		rst(1, 1, 1);
		chk("idleOe", {wtOe, rdyOe, doe}, 4'hf);
		csR = 1'b0;
		repeat (4) @(negedge clk);
		chk("selNoStrobe", {wtOe, wt, rdyOe, rdyN}, 4'h5);
		csR = 1'b1;
		repeat (3) @(negedge clk);
		regRd(1);
		regRd(2);
		for (i = 0; i < 4; i++) regWr(2 + $urandom % 30, $urandom);
		for (i = 2; i < 32; i += 7) regRd(i);
		regWr(6'h21, $urandom);
		regRd(6'h21);
		regWr(0, 16'h0001);
		ev = 8'h01;
		repeat (3) @(negedge clk);
		chk("irqSet", {irqOe, ppIrq, irq}, 3'h0);
		ev = 8'h00;
		regRd(3);
		repeat (2) @(negedge clk);
		chk("irqClr", {irqOe, ppIrq}, 2'h3);
		need = 1'b1;
		repeat (2) @(negedge clk);
		chk("dmaReq", dma_request_out, 1);
		din = $urandom;
		grN = 1'b0;
		for (i = 0; i < 20 && cmdV !== 1'b1; i++) @(posedge clk) #1;
		if (i == 20)
		begin
			chk("timeout", 1, 0);
			tally_and_finish;
		end
		chk("cmdWord", {cmdV, cmdW}, {1'b1, din});
		@(negedge clk);
		{grN, need} = 2'h2;
		v = $urandom;
		acc(1, 1, 22'h12_3456, 0, v);
		chk("memReqAddr", {lastReq.write, lastReq.addr[22:1]}, {1'b1, 22'h12_3456});
		chk("memReqData", lastReq.wdata, v);
		acc(1, 0, 22'h12_3456, 0, 16'h0000);
		chk("memRead", q, 16'hc3a5);
		chk("memRate", dbl, 0);
		rst(1, 0, 0);
		chk("memRate", dbl, 1);
		regWr(6'h21, $urandom);
		regWr(6'h05, $urandom);
		regRd(6'h21);
		regRd(6'h05);
		rst(0, 0, 0);
		regWr(6'h07, $urandom);
		regRd(6'h07);
		regRd(6'h01);
		tally_and_finish;
	end
endmodule : hbi_host_port_tb
